// >>> flash_ctl_regs.vh
// Register offsets, field positions and command codes for the flash controller
// ---------------------------------------------------------------------------
// Overview of operation
// - Host writes read-array to get array data; device returns to array.
// - Every status poll is a fresh read cycle toggling select or enable.
// - Program is setup write then address and data write.
// - Erase is setup write then confirm write with block address.
// ---------------------------------------------------------------------------
`ifndef FLASH_CTL_REGS_VH
`define FLASH_CTL_REGS_VH

// Host register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_STATUS      8'h0c
`define REG_RDATA       8'h10
`define REG_FLASH_STAT  8'h14

// Control register fields
`define CTRL_START      0
`define CTRL_OP_LSB     4
`define CTRL_OP_MSB     7

// Controller status fields
`define STAT_BUSY       0
`define STAT_DONE       1

// Operation codes written to the control register
`define OP_READ_ARRAY   4'h0
`define OP_READ_STATUS  4'h1
`define OP_CLEAR_STATUS 4'h2
`define OP_PROGRAM      4'h3
`define OP_ERASE        4'h4
`define OP_SUSPEND      4'h5
`define OP_RESUME       4'h6
`define OP_READ_QUERY   4'h7
`define OP_POLL         4'h8

// Flash command codes
`define CMD_READ_ARRAY  8'hff
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STAT  8'h50
`define CMD_PROG_SETUP  8'h40
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM     8'hd0
`define CMD_SUSPEND     8'hb0
`define CMD_READ_QUERY  8'h98

// Flash status fields
`define SR_READY        7
`define SR_ERASE_FAIL   5
`define SR_PROG_FAIL    4
`define SR_SUPPLY       3
`define SR_SUSPENDED    2
`define SR_LOCKED       1
`define SR_RESET_VALUE  8'h80

// Bus cycle timing as final count in clk_en cycles; pulse lasts one cycle more, gap at least two cycles more
`define PULSE_CYCLES    3
`define GAP_CYCLES      2

`endif

// >>> flash_bus_cycle.v
// One asynchronous flash bus cycle: a write pulse or a read with capture
`timescale 1ns/1ps
`include "flash_ctl_regs.vh"

module flash_bus_cycle #(
	parameter AW = 22,
	parameter DW = 16
)(
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          ce_en,
	input  wire          start,
	input  wire          is_read,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	input  wire [DW-1:0] dq_in_sync,
	output reg           busy_q,
	output reg           done_q,
	output reg  [DW-1:0] rdata_q,
	output reg           chip_sel_n_q,
	output reg           out_en_n_q,
	output reg           wr_en_n_q,
	output reg  [AW-1:0] addr_q,
	output reg  [DW-1:0] dq_out_q,
	output reg           dq_oe_q
);

	localparam S_IDLE  = 2'd0;
	localparam S_PULSE = 2'd1;
	localparam S_GAP   = 2'd2;

	reg [1:0] state_q;
	reg [3:0] cnt_q;
	reg       rd_q;

	// -------------------------------------------------------------------
	// Cycle engine
	// -------------------------------------------------------------------
	// Every access both raises and drops select and enable, so each
	// status poll is a fresh read that the device latches anew.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_q      <= S_IDLE;
			cnt_q        <= 4'h0;
			rd_q         <= 1'b0;
			busy_q       <= 1'b0;
			done_q       <= 1'b0;
			rdata_q      <= {DW{1'b0}};
			chip_sel_n_q <= 1'b1;
			out_en_n_q   <= 1'b1;
			wr_en_n_q    <= 1'b1;
			addr_q       <= {AW{1'b0}};
			dq_out_q     <= {DW{1'b0}};
			dq_oe_q      <= 1'b0;
		end
		else if (ce_en)
		begin
			done_q <= 1'b0;
			case (state_q)
			S_IDLE:
				if (start)
				begin
					busy_q       <= 1'b1;
					rd_q         <= is_read;
					addr_q       <= addr;
					dq_out_q     <= wdata;
					dq_oe_q      <= ~is_read;
					chip_sel_n_q <= 1'b0;
					out_en_n_q   <= ~is_read;
					wr_en_n_q    <= is_read;
					cnt_q        <= 4'h0;
					state_q      <= S_PULSE;
				end
			S_PULSE:
				if (cnt_q == `PULSE_CYCLES)
				begin
					// Sampling late in the pulse lets the synchroniser settle
					if (rd_q)
						rdata_q <= dq_in_sync;
					chip_sel_n_q <= 1'b1;
					out_en_n_q   <= 1'b1;
					wr_en_n_q    <= 1'b1;
					cnt_q        <= 4'h0;
					state_q      <= S_GAP;
				end
				else
					cnt_q <= cnt_q + 4'h1;
			S_GAP:
				if (cnt_q == `GAP_CYCLES)
				begin
					dq_oe_q <= 1'b0;
					busy_q  <= 1'b0;
					done_q  <= 1'b1;
					state_q <= S_IDLE;
				end
				else
					cnt_q <= cnt_q + 4'h1;
			default:
				state_q <= S_IDLE;
			endcase
		end
	end

endmodule

// >>> flash_status_program_erase_ctl.v
// Host controller driving an asynchronous NOR flash from AHB-Lite registers
`timescale 1ns/1ps
`include "flash_ctl_regs.vh"

module flash_status_program_erase_ctl #(
	parameter AW = 22,
	parameter DW = 16
)(
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          clk_en,
	input  wire          hsel,
	input  wire [31:0]   haddr,
	input  wire [1:0]    htrans,
	input  wire          hwrite,
	input  wire [2:0]    hsize,
	input  wire [31:0]   hwdata,
	input  wire          hready,
	output reg  [31:0]   hrdata,
	output reg           hreadyout,
	output reg           hresp,
	output wire          chip_sel_n,
	output wire          out_en_n,
	output wire          wr_en_n,
	output reg           reset_powerdown_n,
	output wire [AW-1:0] flash_addr,
	output wire [DW-1:0] dq_out,
	output wire          dq_oe,
	input  wire [DW-1:0] dq_in
);

	localparam C_IDLE  = 3'd0;
	localparam C_CMD1  = 3'd1;
	localparam C_WAIT1 = 3'd2;
	localparam C_CMD2  = 3'd3;
	localparam C_WAIT2 = 3'd4;

	reg [31:0]   ctrl_q;
	reg [AW-1:0] addr_reg_q;
	reg [DW-1:0] wdata_q;
	reg [DW-1:0] flash_stat_q;
	reg          done_flag_q;
	reg [2:0]    cstate_q;
	reg [3:0]    op_q;
	reg          cyc_start_q;
	reg          cyc_read_q;
	reg [AW-1:0] cyc_addr_q;
	reg [DW-1:0] cyc_data_q;
	reg [DW-1:0] dq_meta_q;
	reg [DW-1:0] dq_sync_q;
	reg          ph_valid_q;
	reg          ph_write_q;
	reg [7:0]    ph_addr_q;
	wire         cyc_busy;
	wire         cyc_done;
	wire [DW-1:0] cyc_rdata;

	// -------------------------------------------------------------------
	// Pin synchroniser
	// -------------------------------------------------------------------
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dq_meta_q <= {DW{1'b0}};
			dq_sync_q <= {DW{1'b0}};
		end
		else if (clk_en)
		begin
			dq_meta_q <= dq_in;
			dq_sync_q <= dq_meta_q;
		end
	end

	// -------------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// -------------------------------------------------------------------
	wire start_req = ph_valid_q && ph_write_q && (ph_addr_q == `REG_CTRL) &&
		hwdata[`CTRL_START] && (cstate_q == C_IDLE);

	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ph_valid_q <= 1'b0;
			ph_write_q <= 1'b0;
			ph_addr_q  <= 8'h00;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
			ctrl_q     <= 32'h0000_0000;
			addr_reg_q <= {AW{1'b0}};
			wdata_q    <= {DW{1'b0}};
		end
		else if (clk_en)
		begin
			ph_valid_q <= hsel && hready && htrans[1];
			ph_write_q <= hwrite;
			ph_addr_q  <= haddr[7:0];
			if (ph_valid_q && ph_write_q)
			begin
				case (ph_addr_q)
				`REG_CTRL:  ctrl_q     <= hwdata;
				`REG_ADDR:  addr_reg_q <= hwdata[AW-1:0];
				`REG_WDATA: wdata_q    <= hwdata[DW-1:0];
				default:    ;
				endcase
			end
			if (hsel && hready && htrans[1] && !hwrite)
			begin
				case (haddr[7:0])
				`REG_CTRL:       hrdata <= ctrl_q;
				`REG_ADDR:       hrdata <= {{(32-AW){1'b0}}, addr_reg_q};
				`REG_WDATA:      hrdata <= {{(32-DW){1'b0}}, wdata_q};
				`REG_STATUS:     hrdata <= {30'h0, done_flag_q,
					cstate_q != C_IDLE};
				`REG_RDATA:      hrdata <= {{(32-DW){1'b0}}, flash_stat_q};
				`REG_FLASH_STAT: hrdata <= {24'h0, flash_stat_q[7:0]};
				default:         hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// -------------------------------------------------------------------
	// Command sequencer
	// -------------------------------------------------------------------
	// Only one host operation runs at a time; a start while busy is dropped.
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cstate_q          <= C_IDLE;
			op_q              <= `OP_READ_ARRAY;
			cyc_start_q       <= 1'b0;
			cyc_read_q        <= 1'b0;
			cyc_addr_q        <= {AW{1'b0}};
			cyc_data_q        <= {DW{1'b0}};
			flash_stat_q      <= {DW{1'b0}};
			done_flag_q       <= 1'b0;
			reset_powerdown_n <= 1'b0;
		end
		else if (clk_en)
		begin
			reset_powerdown_n <= 1'b1;
			cyc_start_q <= 1'b0;
			case (cstate_q)
			C_IDLE:
				if (start_req)
				begin
					op_q        <= hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
					done_flag_q <= 1'b0;
					cstate_q    <= C_CMD1;
				end
			C_CMD1:
			begin
				cyc_start_q <= 1'b1;
				cyc_read_q  <= 1'b0;
				cyc_addr_q  <= addr_reg_q;
				cstate_q    <= C_WAIT1;
				case (op_q)
				`OP_READ_ARRAY:  cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_READ_ARRAY};
				`OP_READ_STATUS: cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_READ_STATUS};
				`OP_CLEAR_STATUS: cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_CLEAR_STAT};
				`OP_PROGRAM:     cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_PROG_SETUP};
				`OP_ERASE:       cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_ERASE_SETUP};
				`OP_SUSPEND:     cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_SUSPEND};
				`OP_RESUME:      cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_CONFIRM};
				`OP_READ_QUERY:  cyc_data_q <= {{(DW-8){1'b0}},
					`CMD_READ_QUERY};
				default:
				begin
					// Poll: plain read cycle, no command written
					cyc_read_q <= 1'b1;
					cyc_data_q <= {DW{1'b0}};
				end
				endcase
			end
			C_WAIT1:
				if (cyc_done && !cyc_start_q)
				begin
					if (cyc_read_q)
					begin
						flash_stat_q <= cyc_rdata;
						done_flag_q  <= 1'b1;
						cstate_q     <= C_IDLE;
					end
					else if (op_q == `OP_PROGRAM || op_q == `OP_ERASE)
						cstate_q <= C_CMD2;
					else
					begin
						done_flag_q <= 1'b1;
						cstate_q    <= C_IDLE;
					end
				end
			C_CMD2:
			begin
				cyc_start_q <= 1'b1;
				cyc_addr_q  <= addr_reg_q;
				if (op_q == `OP_ERASE)
					cyc_data_q <= {{(DW-8){1'b0}}, `CMD_CONFIRM};
				else
					cyc_data_q <= wdata_q;
				cstate_q <= C_WAIT2;
			end
			C_WAIT2:
				if (cyc_done && !cyc_start_q)
				begin
					done_flag_q <= 1'b1;
					cstate_q    <= C_IDLE;
				end
			default:
				cstate_q <= C_IDLE;
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Flash bus cycle engine
	// -------------------------------------------------------------------
	flash_bus_cycle #(
		.AW (AW),
		.DW (DW)
	) u_cycle (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.ce_en        (clk_en),
		.start        (cyc_start_q),
		.is_read      (cyc_read_q),
		.addr         (cyc_addr_q),
		.wdata        (cyc_data_q),
		.dq_in_sync   (dq_sync_q),
		.busy_q       (cyc_busy),
		.done_q       (cyc_done),
		.rdata_q      (cyc_rdata),
		.chip_sel_n_q (chip_sel_n),
		.out_en_n_q   (out_en_n),
		.wr_en_n_q    (wr_en_n),
		.addr_q       (flash_addr),
		.dq_out_q     (dq_out),
		.dq_oe_q      (dq_oe)
	);

endmodule

// >>> flash_ctl_checker.sv
// Port assertions for the flash controller
`timescale 1ns/1ps
module flash_ctl_checker (
	input logic        hclk,
	input logic        hresetn,
	input logic        hreadyout,
	input logic        hresp,
	input logic        chip_sel_n,
	input logic        out_en_n,
	input logic        wr_en_n,
	input logic        reset_powerdown_n,
	input logic [21:0] flash_addr,
	input logic [15:0] dq_out,
	input logic        dq_oe
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_pulse;
		!chip_sel_n [*4] ##1 chip_sel_n;
	endsequence
	sequence s_gap;
		chip_sel_n [*3];
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	AST_PULSE: assert property ($fell(chip_sel_n) |-> s_pulse)
		else $error("select pulse length wrong");
	AST_GAP: assert property ($rose(chip_sel_n) |-> s_gap)
		else $error("gap between bus cycles too short");
	AST_NO_CLASH: assert property (wr_en_n || out_en_n)
		else $error("write and read strobes both low");
	AST_WR_DRIVE: assert property (!wr_en_n |-> !chip_sel_n && dq_oe)
		else $error("write strobe without select or data");
	AST_RD_FLOAT: assert property (!out_en_n |-> !chip_sel_n && !dq_oe)
		else $error("controller drives data during a read");
	AST_WR_HOLD: assert property (!wr_en_n && !$past(wr_en_n)
		|-> $stable(dq_out) && $stable(flash_addr))
		else $error("write address or data moved under strobe");
	AST_RD_HOLD: assert property (!out_en_n && !$past(out_en_n)
		|-> $stable(flash_addr))
		else $error("read address moved under strobe");
	AST_PD_QUIET: assert property (!reset_powerdown_n |-> chip_sel_n)
		else $error("flash selected while held in reset");
endmodule

bind flash_status_program_erase_ctl flash_ctl_checker flash_ctl_checker_i (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
	.reset_powerdown_n(reset_powerdown_n), .flash_addr(flash_addr),
	.dq_out(dq_out), .dq_oe(dq_oe));

// >>> flash_model.sv
// Behavioural flash device answering the controller's bus cycles
`timescale 1ns/1ps
module flash_model #(
	parameter RUN_TICKS = 80
)(
	input  logic        chip_sel_n,
	input  logic        out_en_n,
	input  logic        wr_en_n,
	input  logic        reset_powerdown_n,
	input  logic [21:0] flash_addr,
	input  logic [15:0] dq_out,
	input  logic        dq_oe,
	output logic [15:0] dq_in
);
	logic [15:0] mem [0:15];
	logic [7:0]  sr = 8'h80;
	logic [1:0]  mode = 0;
	logic [1:0]  pend = 0;
	logic        susp = 0;
	logic        erasing = 0;
	logic [3:0]  tgt = 0;
	logic [15:0] val = 0;
	logic [15:0] snap = 0;
	logic        bad_run = 0;
	logic        wr_on = 0;
	int          left = 0;
	// Released bus shows the inverse so a stale value cannot pass
	assign dq_in = (!chip_sel_n && !out_en_n) ? snap : ~snap;
	initial
		for (int i = 0; i < 16; i++)
			mem[i] = 16'hffff;
	always @(negedge chip_sel_n or negedge out_en_n)
		if (!chip_sel_n && !out_en_n)
			snap = mode == 1 ? {8'h00, sr} :
				mode == 2 ? 16'h0051 : mem[flash_addr[3:0]];
	always @(negedge reset_powerdown_n)
	begin
		sr = 8'h80;
		mode = 0;
		pend = 0;
		left = 0;
		susp = 0;
	end
	// Short run time stands in for the real algorithm duration
	always #100
		if (left != 0 && !susp)
		begin
			left = left - 1;
			if (left == 0)
			begin
				// Failing run leaves the array alone and flags the error
				if (bad_run)
					sr = sr | (erasing ? 8'h20 : 8'h10);
				else if (erasing)
					for (int i = 0; i < 4; i++)
						mem[{tgt[3:2], i[1:0]}] = 16'hffff;
				else
					mem[tgt] = mem[tgt] & val;
				sr[7] = 1'b1;
			end
		end
	task accept(input logic [15:0] d, input logic [3:0] a);
		logic [7:0] c;
		logic       busy;
		c = d[7:0];
		busy = left != 0 && !susp;
		if (pend != 0)
		begin
			mode = 1;
			tgt = a;
			val = d;
			if (pend == 2 && c != 8'hd0)
				sr = sr | 8'h30;
			else if (pend == 1 && a[3:2] == 2'b11)
				sr[1] = 1'b1;
			// Word 10 stands for a bad supply, word 9 for a failing run
			else if (a == 4'ha)
				sr = sr | (pend == 2 ? 8'h28 : 8'h08);
			else
			begin
				erasing = pend == 2;
				bad_run = a == 4'h9;
				sr[7] = 1'b0;
				left = RUN_TICKS;
			end
			pend = 0;
			return;
		end
		if (busy && c != 8'h70 && c != 8'hb0 && c != 8'hd0)
			return;
		if (susp && c != 8'hff && c != 8'h70 && c != 8'h90 && c != 8'h98
			&& c != 8'hd0)
			return;
		case (c)
		8'hff: mode = 0;
		8'h70: mode = 1;
		8'h50: sr = sr & 8'hc5;
		8'h98: mode = 2;
		8'h40: pend = 1;
		8'h20: pend = 2;
		8'hb0: if (busy)
		begin
			susp = 1;
			sr = sr | 8'h84;
			mode = 1;
		end
		8'hd0: if (susp)
		begin
			susp = 0;
			sr = sr & 8'h7b;
			mode = 1;
		end
		default: ;
		endcase
	endtask
	// Latch on whichever of select or write strobe rises first, so the
	// order in which both rise within one step does not matter
	always @(chip_sel_n or wr_en_n)
		if (!chip_sel_n && !wr_en_n && reset_powerdown_n)
			wr_on = 1;
		else if (wr_on)
		begin
			wr_on = 0;
			accept(dq_out, flash_addr[3:0]);
		end
endmodule

// >>> flash_status_program_erase_ctl_test.sv
// Self-checking bench for the flash controller with a behavioural flash
`timescale 1ns/1ps
module flash_status_program_erase_ctl_test;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        chip_sel_n;
	logic        out_en_n;
	logic        wr_en_n;
	logic        reset_powerdown_n;
	logic [21:0] flash_addr;
	logic [15:0] dq_out;
	logic        dq_oe;
	logic [15:0] dq_in;
	logic [7:0]  fs;
	logic [31:0] rd;
	int          bad_count = 0;
	int          checks = 0;
	int          cycles = 0;
	flash_status_program_erase_ctl flash_status_program_erase_ctl_i (
		.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .wr_en_n(wr_en_n), .dq_in(dq_in),
		.reset_powerdown_n(reset_powerdown_n), .flash_addr(flash_addr),
		.dq_out(dq_out), .dq_oe(dq_oe));
	flash_model flash_model_i (
		.chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
		.reset_powerdown_n(reset_powerdown_n), .flash_addr(flash_addr),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	initial
	begin
		hclk = 0;
		forever #25 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			bad_count = bad_count + 1;
			stop_test;
		end
	end
	task stop_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task op(input logic [3:0] c);
		ahb(1, 8'h00, {24'h0, c, 4'h1});
		repeat (2) @(posedge hclk);
		do ahb(0, 8'h0c, 0); while (rd[1] !== 1'b1);
		ahb(0, 8'h14, 0);
		fs = rd[7:0];
		ahb(0, 8'h10, 0);
	endtask
	task prog(input logic [7:0] a, input logic [15:0] d);
		ahb(1, 8'h04, {24'h0, a});
		ahb(1, 8'h08, {16'h0, d});
		op(4'h3);
	endtask
	task read_at(input logic [7:0] a);
		op(4'h0);
		ahb(1, 8'h04, {24'h0, a});
		op(4'h8);
	endtask
	task wait_ready;
		do op(4'h8); while (fs[7] !== 1'b1);
	endtask
	task t_reset;
		op(4'h1);
		op(4'h8);
		chk("status after reset", 8'h80, fs);
		ahb(0, 8'h40, 0);
		chk("unmapped read", 0, rd[15:0]);
	endtask
	task t_program;
		prog(2, 16'h5a5a);
		op(4'h8);
		chk("busy status", 8'h00, fs);
		wait_ready;
		chk("done status", 8'h80, fs);
		read_at(2);
		chk("programmed word", 16'h5a5a, rd[15:0]);
		prog(2, 16'hff0f);
		wait_ready;
		chk("ones kept status", 8'h80, fs);
		read_at(2);
		chk("cells only cleared", 16'h5a0a, rd[15:0]);
	endtask
	task t_suspend;
		prog(4, 16'h1234);
		op(4'h5);
		op(4'h8);
		chk("suspended status", 8'h84, fs);
		read_at(2);
		chk("other block read", 16'h5a0a, rd[15:0]);
		op(4'h6);
		op(4'h8);
		chk("resumed status", 8'h00, fs);
		wait_ready;
		read_at(4);
		chk("resumed word", 16'h1234, rd[15:0]);
	endtask
	task t_locked;
		prog(12, 16'h0000);
		op(4'h8);
		chk("locked abort", 8'h82, fs);
		op(4'h0);
		op(4'h1);
		op(4'h8);
		chk("flag kept", 8'h82, fs);
		op(4'h2);
		op(4'h8);
		chk("flag cleared", 8'h80, fs);
		prog(12, 16'h0000);
		hresetn <= 0;
		@(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		op(4'h1);
		op(4'h8);
		chk("flag after reset", 8'h80, fs);
	endtask
	task t_erase;
		op(4'h2);
		ahb(1, 8'h04, 1);
		op(4'h4);
		op(4'h8);
		chk("erasing status", 8'h00, fs);
		wait_ready;
		read_at(2);
		chk("erased word", 16'hffff, rd[15:0]);
		read_at(4);
		chk("other block kept", 16'h1234, rd[15:0]);
		op(4'h7);
		op(4'h8);
		chk("query word", 16'h0051, rd[15:0]);
		read_at(4);
		chk("array again", 16'h1234, rd[15:0]);
	endtask
	task t_faults;
		op(4'h2);
		prog(9, 16'h0f0f);
		wait_ready;
		chk("verify fail", 8'h90, fs);
		op(4'h2);
		prog(10, 16'h0000);
		op(4'h8);
		chk("program supply", 8'h88, fs);
		op(4'h2);
		ahb(1, 8'h04, 9);
		op(4'h4);
		op(4'h8);
		chk("erase running", 8'h00, fs);
		wait_ready;
		chk("erase fail", 8'ha0, fs);
		op(4'h2);
		ahb(1, 8'h04, 10);
		op(4'h4);
		op(4'h8);
		chk("erase supply", 8'ha8, fs);
		op(4'h2);
		op(4'h8);
		chk("errors cleared", 8'h80, fs);
	endtask
	initial
	begin
		hresetn = 0;
		hsel = 1;
		htrans = 0;
		haddr = 0;
		hwrite = 0;
		hwdata = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		t_reset;
		t_program;
		t_suspend;
		t_locked;
		t_erase;
		t_faults;
		stop_test;
	end
endmodule
